/* File: inc/asc_pkg.sv */
// Purpose: Constants and types for the asynchronous serial channel
// Assumes: Register port with 4-bit index and 16-bit data
// Notes:   Summary of operation below
//
// Summary of operation
// - With 8 data bits, frames go LSB first or MSB first per bit order.
// - Transmitter runs only while transmit enable is one.
// - Receiver runs only while receive enable is one.
// - Data invert select flips transmitted and received data bits.
// - Line polarity select inverts transmit pin and receive pin.
// - Two-bit count source field picks the prescaled baud clock.
// - Handshake select assigns the shared pin to CTS input or RTS output.
// - Handshake disable turns the chosen CTS or RTS function off.
// - Drive select makes the transmit pin push-pull or open-drain.
// - Read-only shift empty flag is set while no frame shifts out.
// - Buffer empty flag is set when transmit buffer data moves to the shift register.
// - Receive complete flag is set when a frame reaches the buffer.
// - Transmit interrupt source is buffer empty or transmission complete.
package asc_pkg;
  localparam logic [3:0] A_MODE = 4'h0;
  localparam logic [3:0] A_CTL0 = 4'h1;
  localparam logic [3:0] A_CTL1 = 4'h2;
  localparam logic [3:0] A_TXB  = 4'h3;
  localparam logic [3:0] A_RXB  = 4'h4;
  localparam logic [3:0] A_BRG  = 4'h5;
  localparam logic [3:0] A_IST  = 4'h6;
  localparam logic [3:0] A_IMSK = 4'h7;
  localparam logic [3:0] A_SMR1 = 4'h8;
  // Mode register fields
  localparam int F_PEN = 4;
  localparam int F_ODD = 5;
  localparam int F_POL = 6;
  // Control 0 fields, count source in [1:0]
  localparam int F_HSSEL = 2;
  localparam int F_TX_SHIFT_EMPTY_FLAG = 3;
  localparam int F_HSDIS = 4;
  localparam int F_OD    = 5;
  localparam int F_ORDER = 7;
  // Control 1 fields
  localparam int F_TE    = 0;
  localparam int F_TI    = 1;
  localparam int F_RE    = 2;
  localparam int F_RI    = 3;
  localparam int F_IRS   = 4;
  localparam int F_INV   = 5;
  // Frame length codes
  localparam logic [2:0] LEN7 = 3'h4;
  localparam logic [2:0] LEN8 = 3'h5;
  localparam logic [2:0] LEN9 = 3'h6;
  localparam logic [7:0] MODE_RST = 8'h05;
  localparam logic [7:0] CTL0_RST = 8'h10;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [7:0] BRG_RST  = 8'h00;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID  = 4'h7;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b010,
    ST_PAR   = 3'b011,
    ST_STOP  = 3'b100
  } asc_st_t;
endpackage

/* File: hw/asc_chan.sv */
// Purpose: Asynchronous serial channel with register port
// Assumes: Single clock, 16x oversampling, one stop bit
// Notes:   Parity bit sent when enabled; received parity is skipped
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module asc_chan
  import asc_pkg::*;
(
  input  wire logic        clk,     // System clock
  input  wire logic        rst_b,   // Async reset, low
  input  wire logic [3:0]  addr,    // Register index
  input  wire logic [15:0] wr_data, // Write data
  input  wire logic        wr_en,   // Write strobe
  input  wire logic        rd_en,   // Read strobe
  output logic      [15:0] rd_data, // Read data, next cycle
  output logic             irq,     // Level interrupt
  output logic             tx_out,  // Transmit pin out
  output logic             tx_oe,   // Transmit pin enable
  input  wire logic        rx_in,   // Receive pin
  input  wire logic        hs_in,   // Handshake pin in
  output logic             hs_out,  // Handshake pin out
  output logic             hs_oe    // Handshake pin enable
);
  logic [7:0]  mode_r, ctl0_r, ctl1_r, brg_r, smr_r;
  logic [1:0]  ist_r, imsk_r;
  logic [8:0]  txb_r, rxb_r, txs_r, rxs_r;
  logic        ti_r, ri_r, txp_r;
  logic [5:0]  pre_r;
  logic [7:0]  brc_r;
  logic [3:0]  txt_r, txi_r, rxt_r, rxi_r;
  asc_st_t     tx_st_r, rx_st_r;
  logic [2:0]  rxsy_r, hssy_r;
  logic        rxf_r, ctsf_r;
  logic [15:0] rd_data_r;
  logic        tx_out_r, tx_oe_r, hs_out_r, hs_oe_r;

  function automatic logic [8:0] asc_ord(input logic [8:0] d, input logic msb);
    logic [8:0] r;
    r = d;
    if (msb)
      for (int i = 0; i < 8; i++)
        r[i] = d[7-i];
    return r;
  endfunction

  function automatic logic [8:0] asc_dmask(input logic [2:0] len);
    return (len == LEN7) ? 9'h07f : (len == LEN9) ? 9'h1ff : 9'h0ff;
  endfunction

  function automatic logic [5:0] asc_pmask(input logic [1:0] sel);
    unique case (sel)
      2'h0: return 6'h00;
      2'h1: return 6'h07;
      2'h2: return 6'h1f;
      2'h3: return 6'h3f;
    endcase
  endfunction

  wire [2:0] len    = mode_r[2:0];
  wire [3:0] nbits  = (len == LEN7) ? 4'h7 : (len == LEN9) ? 4'h9 : 4'h8;
  wire [8:0] dmask  = asc_dmask(len);
  wire       msb    = ctl0_r[F_ORDER] && (len == LEN8);
  wire       pol    = mode_r[F_POL];
  wire       inv    = ctl1_r[F_INV];
  wire       tx_en  = ctl1_r[F_TE];
  wire       rx_en  = ctl1_r[F_RE];
  wire       hs_rts = ctl0_r[F_HSSEL];
  wire       hs_dis = ctl0_r[F_HSDIS];
  wire       wr_txb = wr_en && (addr == A_TXB);
  wire       rd_rxb = rd_en && (addr == A_RXB);
  wire       tx_ept = (tx_st_r == ST_IDLE);
  // CTS gates only the start of a frame, never one in flight
  wire       cts_ok = hs_dis || hs_rts || !ctsf_r;
  wire       tx_load = (tx_st_r == ST_IDLE) && tx_en && !ti_r && cts_ok && !wr_txb;
  wire       src_tk = ((pre_r & asc_pmask(ctl0_r[1:0])) == asc_pmask(ctl0_r[1:0]));
  wire       ovs_tk = src_tk && (brc_r == 8'h00);
  wire       tx_bend = ovs_tk && (txt_r == OVS_LAST);
  wire       tx_done = tx_bend && (tx_st_r == ST_STOP) && tx_en;
  wire       rx_smp = ovs_tk && (rxt_r == OVS_LAST);
  wire       rx_done = rx_smp && (rx_st_r == ST_STOP) && rx_en;
  wire       rxl    = rxf_r ^ pol;
  wire [8:0] rx_al  = rxs_r >> (4'h9 - nbits);
  wire       tx_ev  = ctl1_r[F_IRS] ? tx_done : tx_load;

  // Register writes
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_r <= MODE_RST;
      ctl0_r <= CTL0_RST;
      ctl1_r <= CTL1_RST;
      brg_r  <= BRG_RST;
      smr_r  <= 8'h00;
      imsk_r <= 2'h0;
      txb_r  <= 9'h000;
    end
    else if (wr_en)
    begin
      unique case (addr)
        A_MODE: mode_r <= wr_data[7:0];
        A_CTL0: ctl0_r <= wr_data[7:0];
        A_CTL1: ctl1_r <= wr_data[7:0];
        A_BRG:  brg_r  <= wr_data[7:0];
        A_SMR1: smr_r  <= wr_data[7:0];
        A_IMSK: imsk_r <= wr_data[1:0];
        A_TXB:  txb_r  <= wr_data[8:0];
        default: ;
      endcase
    end
  end

  // Flags: hardware set wins over software clear
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ti_r  <= 1'b1;
      ri_r  <= 1'b0;
      ist_r <= 2'h0;
    end
    else
    begin
      if (tx_load)
        ti_r <= 1'b1;
      else if (wr_txb)
        ti_r <= 1'b0;
      if (rx_done)
        ri_r <= 1'b1;
      else if (rd_rxb)
        ri_r <= 1'b0;
      for (int i = 0; i < 2; i++)
        if ((i == 0) ? tx_ev : rx_done)
          ist_r[i] <= 1'b1;
        else if (wr_en && (addr == A_IST) && wr_data[i])
          ist_r[i] <= 1'b0;
    end
  end

  assign irq = |(ist_r & imsk_r);

  // Read port
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_data_r <= 16'h0000;
    else if (!rd_en)
      rd_data_r <= 16'h0000;
    else
    begin
      unique case (addr)
        A_MODE: rd_data_r <= {8'h00, mode_r};
        A_CTL0: rd_data_r <= {8'h00, ctl0_r[7:4], tx_ept, ctl0_r[2:0]};
        A_CTL1: rd_data_r <= {8'h00, 2'h0, ctl1_r[5:4], ri_r, ctl1_r[2], ti_r, ctl1_r[0]};
        A_TXB:  rd_data_r <= {7'h00, txb_r};
        A_RXB:  rd_data_r <= {7'h00, rxb_r};
        A_BRG:  rd_data_r <= {8'h00, brg_r};
        A_IST:  rd_data_r <= {14'h0000, ist_r};
        A_IMSK: rd_data_r <= {14'h0000, imsk_r};
        A_SMR1: rd_data_r <= {8'h00, smr_r};
        default: rd_data_r <= 16'h0000;
      endcase
    end
  end

  assign rd_data = rd_data_r;

  // Prescaler and baud divider give the 16x tick
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pre_r <= 6'h00;
      brc_r <= 8'h00;
    end
    else
    begin
      pre_r <= pre_r + 6'h01;
      if (src_tk)
        brc_r <= (brc_r == 8'h00) ? brg_r : brc_r - 8'h01;
    end
  end

  // Pin synchronisers; a change counts once stages 2 and 3 agree
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rxsy_r <= 3'h7;
      hssy_r <= 3'h7;
      rxf_r  <= 1'b1;
      ctsf_r <= 1'b1;
    end
    else
    begin
      rxsy_r <= {rxsy_r[1:0], rx_in};
      hssy_r <= {hssy_r[1:0], hs_in};
      if (rxsy_r[1] == rxsy_r[2])
        rxf_r <= rxsy_r[2];
      if (hssy_r[1] == hssy_r[2])
        ctsf_r <= hssy_r[2];
    end
  end

  // Transmitter
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_st_r <= ST_IDLE;
      txt_r   <= 4'h0;
      txi_r   <= 4'h0;
      txs_r   <= 9'h000;
      txp_r   <= 1'b0;
    end
    else if (!tx_en)
      tx_st_r <= ST_IDLE;
    else if (tx_load)
    begin
      tx_st_r <= ST_START;
      txt_r   <= 4'h0;
      txi_r   <= 4'h0;
      txs_r   <= (asc_ord(txb_r, msb) ^ {9{inv}}) & dmask;
      txp_r   <= ^((asc_ord(txb_r, msb) ^ {9{inv}}) & dmask) ^ mode_r[F_ODD];
    end
    else if (tx_st_r != ST_IDLE && ovs_tk)
    begin
      txt_r <= txt_r + 4'h1;
      if (tx_bend)
      begin
        unique case (tx_st_r)
          ST_START: tx_st_r <= ST_DATA;
          ST_DATA:
          begin
            txs_r <= {1'b0, txs_r[8:1]};
            txi_r <= txi_r + 4'h1;
            if (txi_r == nbits - 4'h1)
              tx_st_r <= mode_r[F_PEN] ? ST_PAR : ST_STOP;
          end
          ST_PAR:  tx_st_r <= ST_STOP;
          ST_STOP: tx_st_r <= ST_IDLE;
          default: tx_st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Pin drivers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_out_r <= 1'b1;
      tx_oe_r  <= 1'b1;
      hs_out_r <= 1'b1;
      hs_oe_r  <= 1'b0;
    end
    else
    begin
      logic lvl;
      unique case (tx_st_r)
        ST_START: lvl = 1'b0;
        ST_DATA:  lvl = txs_r[0];
        ST_PAR:   lvl = txp_r;
        default:  lvl = 1'b1;
      endcase
      lvl = lvl ^ pol;
      // Open-drain only pulls low; idle high comes from the pull-up
      tx_out_r <= ctl0_r[F_OD] ? 1'b0 : lvl;
      tx_oe_r  <= ctl0_r[F_OD] ? !lvl : 1'b1;
      hs_oe_r  <= hs_rts && !hs_dis;
      hs_out_r <= !(rx_en && !ri_r);
    end
  end

  assign tx_out = tx_out_r;
  assign tx_oe  = tx_oe_r;
  assign hs_out = hs_out_r;
  assign hs_oe  = hs_oe_r;

  // Receiver
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_st_r <= ST_IDLE;
      rxt_r   <= 4'h0;
      rxi_r   <= 4'h0;
      rxs_r   <= 9'h000;
      rxb_r   <= 9'h000;
    end
    else if (!rx_en)
      rx_st_r <= ST_IDLE;
    else if (rx_st_r == ST_IDLE)
    begin
      rxt_r <= 4'h0;
      rxi_r <= 4'h0;
      if (!rxl)
        rx_st_r <= ST_START;
    end
    else if (ovs_tk)
    begin
      rxt_r <= rxt_r + 4'h1;
      if (rx_st_r == ST_START && rxt_r == OVS_MID)
      begin
        rxt_r <= 4'h0;
        rx_st_r <= rxl ? ST_IDLE : ST_DATA;
      end
      else if (rx_smp)
      begin
        unique case (rx_st_r)
          ST_DATA:
          begin
            rxs_r <= {rxl, rxs_r[8:1]};
            rxi_r <= rxi_r + 4'h1;
            if (rxi_r == nbits - 4'h1)
              rx_st_r <= mode_r[F_PEN] ? ST_PAR : ST_STOP;
          end
          ST_PAR:  rx_st_r <= ST_STOP;
          ST_STOP:
          begin
            rx_st_r <= ST_IDLE;
            rxb_r   <= asc_ord((rx_al ^ {9{inv}}) & dmask, msb);
          end
          default: rx_st_r <= ST_IDLE;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_tx_load;
    tx_st_r == ST_IDLE ##1 tx_st_r == ST_START;
  endsequence

  sequence s_ctl0_busy_rd;
    rd_en && addr == A_CTL0 && tx_st_r != ST_IDLE;
  endsequence

  tx_gate_a: assert property (tx_st_r == ST_IDLE && !tx_en |=> tx_st_r == ST_IDLE)
    else $error("transmit started while disabled");
  rx_gate_a: assert property (rx_st_r == ST_IDLE && !rx_en |=> rx_st_r == ST_IDLE)
    else $error("receive started while disabled");
  tx_shift_empty_flag_read_a: assert property (s_ctl0_busy_rd |=> !rd_data[F_TX_SHIFT_EMPTY_FLAG])
    else $error("shift empty read high while busy");
  ti_on_load_a: assert property (s_tx_load |-> ti_r)
    else $error("buffer empty not set on load");
  ti_clear_a: assert property (wr_txb && !tx_load |=> !ti_r)
    else $error("buffer write left empty flag set");
  ri_clear_a: assert property (rd_rxb && !rx_done |=> !ri_r ##1 !ri_r || $past(rx_done))
    else $error("receive buffer read left flag set");
  rx_flag_set_a: assert property (rx_done |=> ri_r && ist_r[1])
    else $error("receive complete not flagged");
  tx_irq_src_a: assert property (ctl1_r[F_IRS] && tx_done |=> ist_r[0])
    else $error("tx complete interrupt missing");
  tx_pol_a: assert property (tx_st_r == ST_START && !ctl0_r[F_OD] && $stable(pol) |=> tx_out == pol)
    else $error("start bit level wrong for polarity");
endmodule

/* File: tb/asc_remote.sv */
// Purpose: Remote serial device on the transmit and receive wires
// Assumes: 8 data bits, no parity, one stop bit, 16 clocks a bit
// Notes:   Bit time fixed to the fastest count source and BRG zero
`timescale 1ns/1ps
module asc_remote
(
  input  wire logic clk,  // System clock
  input  wire logic line, // Level on the transmit wire
  output logic      rx_o  // Drive onto the receive pin
);
  logic [7:0] last;
  int         cnt;
  initial
  begin
    rx_o = 1'b1;
    cnt  = 0;
    last = 8'h00;
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      rx_o <= f[i];
      repeat (15) @(posedge clk);
    end
  endtask
  // Mid-bit sampling tolerates the sync delay of the sender
  always
  begin
    @(negedge line);
    repeat (8) @(posedge clk);
    if (!line)
    begin
      for (int i = 0; i < 8; i++)
      begin
        repeat (16) @(posedge clk);
        last[i] = line;
      end
      repeat (16) @(posedge clk);
      cnt++;
    end
  end
endmodule

/* File: tb/tb_async_serial_channel_setup.sv */
// Purpose: Self-checking bench for the serial channel
// Assumes: BRG zero and count source /1, so a bit is 16 clocks
// Notes:   Released transmit wire is pulled up
`timescale 1ns/1ps
module tb_async_serial_channel_setup
  import asc_pkg::*;
;
  logic        clk, rst_b, wr_en, rd_en, hs_in, line;
  logic [3:0]  addr;
  logic [15:0] wr_data, rd_data;
  logic        irq, tx_out, tx_oe, rx_in, hs_out, hs_oe;
  int          bad_count, cmp_count, cyc, base;
  assign line = tx_oe ? tx_out : 1'b1;
  asc_chan u_dut (
    .clk     (clk),
    .rst_b   (rst_b),
    .addr    (addr),
    .wr_data (wr_data),
    .wr_en   (wr_en),
    .rd_en   (rd_en),
    .rd_data (rd_data),
    .irq     (irq),
    .tx_out  (tx_out),
    .tx_oe   (tx_oe),
    .rx_in   (rx_in),
    .hs_in   (hs_in),
    .hs_out  (hs_out),
    .hs_oe   (hs_oe)
  );
  asc_remote u_rem (
    .clk  (clk),
    .line (line),
    .rx_o (rx_in)
  );
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      test_done();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input string n);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(n, e, rd_data);
  endtask
  task automatic tx(input logic [7:0] d);
    base = u_rem.cnt;
    wr(A_TXB, {8'h00, d});
  endtask
  // Absence of a frame can only be judged after a full frame time
  task automatic frames(input int n, input logic [7:0] e);
    for (int k = 0; k < 700 && u_rem.cnt < base + n; k++)
      @(posedge clk);
    repeat (n == 0 ? 300 : 20) @(posedge clk);
    chk("frame count", 16'(base + n), 16'(u_rem.cnt));
    chk("frame byte", {8'h00, e}, {8'h00, u_rem.last});
  endtask
  task automatic irq_is(input logic e);
    for (int k = 0; k < 400 && irq !== e; k++)
    begin
      @(posedge clk);
      #1;
    end
    chk("irq", {15'h0000, e}, {15'h0000, irq});
  endtask
  task automatic t_reset();
    rd(A_MODE, 16'h0005, "mode");
    rd(A_CTL0, 16'h0018, "ctl0");
    rd(A_CTL1, 16'h0002, "ctl1");
    rd(4'hf, 16'h0000, "unmapped");
    chk("tx_oe", 16'h0001, {15'h0000, tx_oe});
    wr(A_SMR1, 16'h0000);
  endtask
  task automatic t_tx();
    wr(A_CTL1, 16'h0001);
    tx(8'ha3);
    frames(1, 8'ha3);
    wr(A_CTL0, 16'h0090);
    tx(8'ha3);
    frames(1, 8'hc5);
    wr(A_CTL0, 16'h0010);
    base = u_rem.cnt;
    wr(A_TXB, 16'h0011);
    wr(A_TXB, 16'h0022);
    rd(A_CTL1, 16'h0001, "ti busy");
    rd(A_CTL0, 16'h0010, "shift busy");
    frames(2, 8'h22);
    rd(A_CTL0, 16'h0018, "shift empty");
    wr(A_CTL1, 16'h0021);
    tx(8'h0f);
    frames(1, 8'hf0);
    wr(A_CTL1, 16'h0000);
    tx(8'h55);
    frames(0, 8'hf0);
    wr(A_CTL1, 16'h0001);
    frames(1, 8'h55);
  endtask
  // Count source /8: start bit lasts 16 ticks, first tick lands anywhere in 8 clocks
  task automatic t_rate();
    int n;
    n = 0;
    wr(A_CTL0, 16'h0011);
    wr(A_CTL1, 16'h0001);
    wr(A_TXB, 16'h00ff);
    @(negedge line);
    while (line === 1'b0 && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("start bit clocks", 16'h0001, {15'h0000, (n >= 121 && n <= 128)});
    repeat (1300) @(posedge clk);
    wr(A_CTL0, 16'h0010);
  endtask
  task automatic t_irq();
    wr(A_IST, 16'h0003);
    wr(A_IMSK, 16'h0001);
    irq_is(1'b0);
    tx(8'h12);
    irq_is(1'b1);
    frames(1, 8'h12);
    wr(A_IST, 16'h0001);
    irq_is(1'b0);
    wr(A_CTL1, 16'h0011);
    tx(8'h34);
    repeat (40) @(posedge clk);
    chk("irq early", 16'h0000, {15'h0000, irq});
    frames(1, 8'h34);
    irq_is(1'b1);
    wr(A_IST, 16'h0001);
    wr(A_IMSK, 16'h0002);
    wr(A_CTL1, 16'h0004);
    u_rem.send(8'h5a);
    irq_is(1'b1);
    rd(A_CTL1, 16'h000e, "ri set");
    rd(A_RXB, 16'h005a, "rx byte");
    rd(A_CTL1, 16'h0006, "ri clear");
    wr(A_IST, 16'h0002);
    irq_is(1'b0);
    wr(A_CTL1, 16'h0000);
    u_rem.send(8'h33);
    repeat (30) @(posedge clk);
    rd(A_CTL1, 16'h0002, "rx off");
    rd(A_RXB, 16'h005a, "rx kept");
  endtask
  task automatic t_pins();
    wr(A_CTL0, 16'h0030);
    repeat (3) @(posedge clk);
    chk("open drain oe", 16'h0000, {15'h0000, tx_oe});
    wr(A_CTL0, 16'h0004);
    wr(A_CTL1, 16'h0004);
    repeat (3) @(posedge clk);
    chk("rts", 16'h0002, {14'h0000, hs_oe, hs_out});
    wr(A_CTL0, 16'h0010);
    repeat (3) @(posedge clk);
    chk("rts off", 16'h0000, {15'h0000, hs_oe});
    wr(A_CTL0, 16'h0000);
    hs_in <= 1'b1;
    wr(A_CTL1, 16'h0001);
    tx(8'h66);
    frames(0, 8'h34);
    hs_in <= 1'b0;
    frames(1, 8'h66);
    wr(A_MODE, 16'h0045);
    repeat (3) @(posedge clk);
    chk("idle level", 16'h0000, {15'h0000, line});
  endtask
  initial
  begin
    rst_b     = 1'b0;
    wr_en     = 1'b0;
    rd_en     = 1'b0;
    addr      = 4'h0;
    wr_data   = 16'h0000;
    hs_in     = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    cyc       = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_tx();
    t_rate();
    t_irq();
    t_pins();
    test_done();
  end
endmodule
